//--- logic/mlp_params.svh
// offsets, field positions and layout constants of the mesh logon parser
`ifndef MLP_PARAMS_SVH
`define MLP_PARAMS_SVH
// register byte addresses
`define MLP_A_CTRL 8'h00
`define MLP_A_STATUS 8'h04
`define MLP_A_IDS 8'h08
`define MLP_A_FLAGS 8'h0C
`define MLP_A_UPLINK 8'h10
`define MLP_A_UPSIG 8'h14
`define MLP_A_DNSIG 8'h18
`define MLP_A_PIDS 8'h1C
`define MLP_A_STAR_RATE 8'h20
`define MLP_A_STAR_MAX 8'h24
`define MLP_A_STAR_VT 8'h28
`define MLP_A_MESH_RATE 8'h2C
`define MLP_A_MESH_MAX 8'h30
`define MLP_A_MESH_VT 8'h34
// register fields and reset values
`define MLP_CTRL_EN 0
`define MLP_CTRL_TAG_LSB 8
`define MLP_ST_ERR 0
`define MLP_ST_VALID 1
`define MLP_ST_BUSY 2
`define MLP_TAG_RST 8'hA5
`define MLP_EN_RST 1'b1
// body byte positions, counted from the first byte after the length
`define MLP_BODY_MAX 8'h20
`define MLP_B_GROUP 5'h00
`define MLP_B_SESS 5'h01
`define MLP_B_FLAGS1 5'h03
`define MLP_B_FLAGS2 5'h04
`define MLP_B_PATH 5'h05
`define MLP_B_CIRC 5'h06
`define MLP_B_DNPATH 5'h09
`define MLP_B_DNCIRC 5'h0A
`define MLP_B_SHORT_END 5'h08
`define MLP_B_LONG_END 5'h0C
`define MLP_GRP_LEN 5'h0A
`define MLP_G_VOL 5'h03
`define MLP_G_MAX 5'h05
`define MLP_G_TMO 5'h08
`define MLP_LEN_FIXED 8'h05
// flag bit positions in the two flag bytes
`define MLP_F1_CC 5
`define MLP_F1_SH 4
`define MLP_F1_PF 3
`define MLP_F1_DU 2
`define MLP_F1_MS 1
`define MLP_F1_CMS 0
`define MLP_F2_MESH 7
`define MLP_F2_STAR 6
`define MLP_F2_BT 5
`define MLP_F2_CONN 4
// default signalling circuit when none is signalled
`define MLP_SIG_VPI_DEF 8'h00
`define MLP_SIG_VCI_DEF 16'h0005
`endif

//--- logic/mlp_pkg.sv
// types shared by the mesh logon descriptor parser
package mlp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LEN = 3'b010,
        ST_BODY = 3'b100
    } mlp_state_e;

    typedef struct packed {
        logic [23:0] guaranteed_rate;
        logic [10:0] volume_max;
        logic [23:0] rate_max;
        logic [15:0] rate_timeout;
        logic timeout_enabled;
    } mlp_cap_s;

    typedef struct packed {
        logic atm_connectivity;
        logic mpeg_bursts;
        logic star_absent;
        logic mesh_absent;
        logic cont_mini_slot;
        logic mini_slot;
        logic labelling;
        logic prefix;
        logic handshake;
        logic mftdma;
    } mlp_flags_s;

    typedef struct packed {
        logic [7:0] terminal_a;
        logic [15:0] terminal_session_id;
        mlp_flags_s flags;
        logic [7:0] uplink_path_id;
        logic [15:0] uplink_circuit_id;
        logic [7:0] uplink_sig_path_id;
        logic [15:0] uplink_sig_circuit_id;
        logic [7:0] downlink_sig_path_id;
        logic [15:0] downlink_sig_circuit_id;
        logic [12:0] uplink_traffic_packet_id;
        logic [12:0] uplink_control_packet_id;
        mlp_cap_s star;
        mlp_cap_s mesh;
    } mlp_settings_s;
endpackage : mlp_pkg

//--- logic/mlp_parser.sv
// mesh logon descriptor parser with its ahb-lite register slave
//
// Functional notes
// - tag byte, then length counting following bytes
// - capture 8-bit terminal group
// - capture 16-bit terminal session id
// - skip two reserved bits, take air-interface bit
// - next bit is security handshake required
// - prefix, labelling, mini-slot, contention mini-slot flags
// - mesh flag zero means mesh group present
// - star flag zero means star group present
// - burst type: zero atm, one transport stream
// - connectivity bit only for atm bursts
// - transport stream bursts imply ip connectivity
// - atm ip: four reserved, path, circuit
// - atm connectivity: uplink signalling path, circuit
// - then eight reserved, downlink signalling path, circuit
// - transport stream: 13-bit uplink traffic packet id
// - three reserved, then 13-bit control packet id
// - star group: rate, volume, rate max, timeout
// - star timeout zero disables it
// - volume maximum may be averaged downstream
// - mesh group follows star, same layout
// - mesh timeout zero disables it
// - reserved bits dropped without any check
// - descriptor replaces plain logon set for mesh
`timescale 1ns/100ps
`include "mlp_params.svh"

module mlp_parser (
    // clock, reset and enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // descriptor byte stream
    input wire logic in_valid,
    input wire logic in_start,
    input wire logic [7:0] in_byte,
    // extracted settings
    output mlp_pkg::mlp_settings_s settings,
    output logic settings_valid,
    output logic parse_error,
    output logic parse_done
);

    mlp_pkg::mlp_state_e state_q;
    logic [7:0] len_q;
    logic [7:0] cnt_q;
    logic match_q;
    logic fin_q;
    logic [7:0] body_q [`MLP_BODY_MAX];
    logic enable_q;
    logic [7:0] tag_q;
    logic err_q;
    logic valid_q;
    mlp_pkg::mlp_settings_s settings_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic [7:0] f1;
    logic [7:0] f2;
    logic [4:0] star_base;
    logic [4:0] mesh_base;
    logic [7:0] elen;
    logic ok_w;
    mlp_pkg::mlp_settings_s dec;

    wire take = ce && in_valid;
    wire last_body = (state_q == mlp_pkg::ST_BODY) && (cnt_q + 8'h01 == len_q);
    wire empty_len = (state_q == mlp_pkg::ST_LEN) && (in_byte == 8'h00);
    wire fin_w = take && !in_start && match_q && (last_body || empty_len);
    wire abort_w = take && in_start && match_q && (state_q != mlp_pkg::ST_IDLE);
    wire bad_w = (fin_q && !ok_w) || abort_w;
    wire acc = ce && hsel && hready && htrans[1];
    wire clr_w = wr_pend_q && (wr_addr_q == `MLP_A_STATUS) && hwdata[`MLP_ST_ERR];

    // tag and length header walk; other descriptors are counted past unstored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= mlp_pkg::ST_IDLE;
            len_q <= 8'h00;
            cnt_q <= 8'h00;
            match_q <= 1'b0;
        end else if (take) begin
            if (in_start) begin
                state_q <= mlp_pkg::ST_LEN;
                match_q <= enable_q && (in_byte == tag_q);
                cnt_q <= 8'h00;
            end else begin
                case (state_q)
                    mlp_pkg::ST_LEN: begin
                        len_q <= in_byte;
                        cnt_q <= 8'h00;
                        state_q <= empty_len ? mlp_pkg::ST_IDLE : mlp_pkg::ST_BODY;
                    end
                    mlp_pkg::ST_BODY: begin
                        cnt_q <= cnt_q + 8'h01;
                        if (last_body) begin
                            state_q <= mlp_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= mlp_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // body bytes kept for decode; bytes beyond the longest layout are only counted
    always_ff @(posedge hclk) begin
        if (take && !in_start && match_q && state_q == mlp_pkg::ST_BODY
                && cnt_q < `MLP_BODY_MAX) begin
            body_q[cnt_q[4:0]] <= in_byte;
        end
    end

    // decode runs a cycle after the last byte so the array is complete
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fin_q <= 1'b0;
        end else if (ce) begin
            fin_q <= fin_w;
        end
    end

    function automatic logic [23:0] get24(input logic [4:0] b);
        return {body_q[b], body_q[b + 5'h01], body_q[b + 5'h02]};
    endfunction : get24

    function automatic logic [15:0] get16(input logic [4:0] b);
        return {body_q[b], body_q[b + 5'h01]};
    endfunction : get16

    // one capacity group, reserved bits above the volume dropped
    function automatic mlp_pkg::mlp_cap_s get_cap(input logic [4:0] b);
        mlp_pkg::mlp_cap_s c;
        c.guaranteed_rate = get24(b);
        c.volume_max = 11'(get16(b + `MLP_G_VOL));
        c.rate_max = get24(b + `MLP_G_MAX);
        c.rate_timeout = get16(b + `MLP_G_TMO);
        c.timeout_enabled = (c.rate_timeout != 16'h0000);
        return c;
    endfunction : get_cap

    // layout walk: fixed part, burst branch, optional star and mesh groups
    always_comb begin
        f1 = body_q[`MLP_B_FLAGS1];
        f2 = body_q[`MLP_B_FLAGS2];
        dec = '0;
        dec.terminal_a = body_q[`MLP_B_GROUP];
        dec.terminal_session_id = get16(`MLP_B_SESS);
        dec.flags.mftdma = f1[`MLP_F1_CC];
        dec.flags.handshake = f1[`MLP_F1_SH];
        dec.flags.prefix = f1[`MLP_F1_PF];
        dec.flags.labelling = f1[`MLP_F1_DU];
        dec.flags.mini_slot = f1[`MLP_F1_MS];
        dec.flags.cont_mini_slot = f1[`MLP_F1_CMS];
        dec.flags.mesh_absent = f2[`MLP_F2_MESH];
        dec.flags.star_absent = f2[`MLP_F2_STAR];
        dec.flags.mpeg_bursts = f2[`MLP_F2_BT];
        dec.uplink_sig_path_id = `MLP_SIG_VPI_DEF;
        dec.uplink_sig_circuit_id = `MLP_SIG_VCI_DEF;
        dec.downlink_sig_path_id = `MLP_SIG_VPI_DEF;
        dec.downlink_sig_circuit_id = `MLP_SIG_VCI_DEF;
        star_base = `MLP_B_SHORT_END;
        if (f2[`MLP_F2_BT]) begin
            // no connectivity bit: ip is implied
            dec.flags.atm_connectivity = 1'b0;
            dec.uplink_traffic_packet_id = 13'(get16(`MLP_B_FLAGS2));
            dec.uplink_control_packet_id = 13'(get16(`MLP_B_CIRC));
        end else begin
            dec.flags.atm_connectivity = f2[`MLP_F2_CONN];
            if (!f2[`MLP_F2_CONN]) begin
                dec.uplink_path_id = body_q[`MLP_B_PATH];
                dec.uplink_circuit_id = get16(`MLP_B_CIRC);
            end else begin
                dec.uplink_sig_path_id = body_q[`MLP_B_PATH];
                dec.uplink_sig_circuit_id = get16(`MLP_B_CIRC);
                dec.downlink_sig_path_id = body_q[`MLP_B_DNPATH];
                dec.downlink_sig_circuit_id = get16(`MLP_B_DNCIRC);
                star_base = `MLP_B_LONG_END;
            end
        end
        // volume is passed on raw; any averaging policy lives downstream
        mesh_base = star_base;
        if (!f2[`MLP_F2_STAR]) begin
            dec.star = get_cap(star_base);
            mesh_base = star_base + `MLP_GRP_LEN;
        end
        elen = {3'h0, mesh_base};
        if (!f2[`MLP_F2_MESH]) begin
            dec.mesh = get_cap(mesh_base);
            elen = elen + {3'h0, `MLP_GRP_LEN};
        end
        // a length shorter than the flag bytes cannot be trusted at all
        ok_w = (len_q >= `MLP_LEN_FIXED) && (len_q == elen);
    end

    // settings only change on a clean descriptor; a bad one clears valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settings_q <= '0;
            valid_q <= 1'b0;
        end else if (ce) begin
            if (fin_q && ok_w) begin
                settings_q <= dec;
                valid_q <= 1'b1;
            end else if (bad_w) begin
                valid_q <= 1'b0;
            end
        end
    end

    // sticky error; a new error in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_q <= 1'b0;
        end else if (ce) begin
            err_q <= (err_q && !clr_w) || bad_w;
        end
    end

    // ahb data phase: writes land one cycle after the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hreadyout_q <= 1'b1;
        end else if (ce) begin
            wr_pend_q <= acc && hwrite;
            wr_addr_q <= haddr[7:0];
            hreadyout_q <= 1'b1;
        end
    end

    // control register steers tag filter and enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= `MLP_EN_RST;
            tag_q <= `MLP_TAG_RST;
        end else if (ce && wr_pend_q && wr_addr_q == `MLP_A_CTRL) begin
            enable_q <= hwdata[`MLP_CTRL_EN];
            tag_q <= hwdata[`MLP_CTRL_TAG_LSB +: 8];
        end
    end

    // read mux; unmapped words read zero with an okay response
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            `MLP_A_CTRL: begin
                r[`MLP_CTRL_EN] = enable_q;
                r[`MLP_CTRL_TAG_LSB +: 8] = tag_q;
            end
            `MLP_A_STATUS: begin
                r[`MLP_ST_ERR] = err_q;
                r[`MLP_ST_VALID] = valid_q;
                r[`MLP_ST_BUSY] = (state_q != mlp_pkg::ST_IDLE);
            end
            `MLP_A_IDS: r = {8'h00, settings_q.terminal_session_id, settings_q.terminal_a};
            `MLP_A_FLAGS: r = {22'h000000, settings_q.flags};
            `MLP_A_UPLINK: r = {8'h00, settings_q.uplink_circuit_id, settings_q.uplink_path_id};
            `MLP_A_UPSIG: begin
                r = {8'h00, settings_q.uplink_sig_circuit_id, settings_q.uplink_sig_path_id};
            end
            `MLP_A_DNSIG: begin
                r = {8'h00, settings_q.downlink_sig_circuit_id,
                    settings_q.downlink_sig_path_id};
            end
            `MLP_A_PIDS: begin
                r = {3'h0, settings_q.uplink_control_packet_id,
                    3'h0, settings_q.uplink_traffic_packet_id};
            end
            `MLP_A_STAR_RATE: r = {8'h00, settings_q.star.guaranteed_rate};
            `MLP_A_STAR_MAX: r = {8'h00, settings_q.star.rate_max};
            `MLP_A_STAR_VT: begin
                r = {settings_q.star.rate_timeout, 4'h0,
                    settings_q.star.timeout_enabled, settings_q.star.volume_max};
            end
            `MLP_A_MESH_RATE: r = {8'h00, settings_q.mesh.guaranteed_rate};
            `MLP_A_MESH_MAX: r = {8'h00, settings_q.mesh.rate_max};
            `MLP_A_MESH_VT: begin
                r = {settings_q.mesh.rate_timeout, 4'h0,
                    settings_q.mesh.timeout_enabled, settings_q.mesh.volume_max};
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : rd_mux

    // read data is sampled at the address phase, so no wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata_q <= rd_mux(haddr[7:0]);
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign settings = settings_q;
    assign settings_valid = valid_q;
    assign parse_error = err_q;
    assign parse_done = fin_q;

    // checks
    a_done_after_end: assert property (@(posedge hclk) disable iff (!hresetn)
        fin_w |=> parse_done)
        else $error("done pulse missing after last body byte");

    a_body_len_end: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !in_start && last_body) |=> (state_q == mlp_pkg::ST_IDLE))
        else $error("body walk did not stop at declared length");

    a_bad_len_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && fin_q && !ok_w) |=> (parse_error && !settings_valid))
        else $error("length mismatch not flagged");

    a_group_capture: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && fin_q && ok_w) |=> (settings_valid && settings.terminal_a == $past(dec.terminal_a)
            && settings.terminal_session_id == $past(dec.terminal_session_id)))
        else $error("identifiers not captured");

    a_mpeg_is_ip: assert property (@(posedge hclk) disable iff (!hresetn)
        (settings_valid && settings.flags.mpeg_bursts) |-> !settings.flags.atm_connectivity)
        else $error("transport stream bursts reported atm connectivity");

    a_sig_default: assert property (@(posedge hclk) disable iff (!hresetn)
        (settings_valid && !settings.flags.atm_connectivity)
            |-> (settings.uplink_sig_circuit_id == `MLP_SIG_VCI_DEF
            && settings.downlink_sig_path_id == `MLP_SIG_VPI_DEF))
        else $error("default signalling circuit lost");

    a_tmo_disable: assert property (@(posedge hclk) disable iff (!hresetn)
        (settings.star.timeout_enabled == (settings.star.rate_timeout != 16'h0000))
        && (settings.mesh.timeout_enabled == (settings.mesh.rate_timeout != 16'h0000)))
        else $error("zero timeout not treated as disabled");

    a_err_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && bad_w && clr_w) |=> parse_error)
        else $error("error lost in clearing cycle");

    a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc && !hwrite && haddr[7:0] > `MLP_A_MESH_VT) |=> (hrdata == 32'h0000_0000))
        else $error("unmapped read not zero");

endmodule : mlp_parser

//--- verification/mlp_source.sv
// upstream byte source that hands descriptor bytes to the parser
`timescale 1ns/100ps
module mlp_source (
    // clock
    input wire logic hclk,
    // byte stream towards the parser
    output logic in_valid,
    output logic in_start,
    output logic [7:0] in_byte
);
    // quiet line at time zero
    initial begin
        in_valid = 1'b0;
        in_start = 1'b0;
        in_byte = 8'h00;
    end

    // one byte a cycle; the idle line shows the inverse of the last byte, not a stale copy
    task send(input logic [7:0] b [0:63], input logic s [0:63], input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            in_valid <= 1'b1;
            in_start <= s[i];
            in_byte <= b[i];
        end
        @(posedge hclk);
        in_valid <= 1'b0;
        in_start <= 1'b0;
        in_byte <= ~b[n - 1];
    endtask : send
endmodule : mlp_source

//--- verification/testbench.sv
// self-checking bench for the mesh logon descriptor parser
`timescale 1ns/100ps
`include "mlp_params.svh"
module testbench;
    typedef struct packed {
        logic bt;
        logic conn;
        logic sa;
        logic ma;
        logic [5:0] f6;
        logic [15:0] tmo;
        logic [7:0] len;
    } mlp_row_s;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    wire logic in_valid;
    wire logic in_start;
    wire logic [7:0] in_byte;
    mlp_pkg::mlp_settings_s settings;
    mlp_pkg::mlp_settings_s exp;
    mlp_pkg::mlp_settings_s save;
    logic settings_valid;
    logic parse_error;
    logic parse_done;
    logic [7:0] bq [0:63];
    logic sq [0:63];
    logic [31:0] rd;
    int nq;
    int bad_count = 0;
    int compares = 0;
    // burst type, connectivity, star absent, mesh absent, flags, timeout, length
    mlp_row_s rows [0:4] = '{
        {1'b0, 1'b0, 1'b0, 1'b0, 6'h2A, 16'h0000, 8'h1C},
        {1'b0, 1'b1, 1'b1, 1'b0, 6'h15, 16'h1234, 8'h16},
        {1'b1, 1'b0, 1'b0, 1'b1, 6'h3F, 16'h0001, 8'h12},
        {1'b1, 1'b0, 1'b1, 1'b1, 6'h00, 16'hFFFF, 8'h08},
        {1'b0, 1'b1, 1'b0, 1'b0, 6'h01, 16'h8000, 8'h20}};

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    always #5 hclk = ~hclk;

    mlp_parser u_mlp_parser (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .in_valid(in_valid), .in_start(in_start), .in_byte(in_byte), .settings(settings),
        .settings_valid(settings_valid), .parse_error(parse_error), .parse_done(parse_done));

    mlp_source u_mlp_source (.hclk(hclk), .in_valid(in_valid), .in_start(in_start),
        .in_byte(in_byte));

    task finish_test;
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task check(input string name, input logic [299:0] seen, input logic [299:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, want, seen);
        end
    endtask : check

    // bounded wait for the slave to sample ready high
    task wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) begin
            bad_count++;
            finish_test();
        end
    endtask : wait_rdy

    // one single word transfer; read data lands in rd
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : ahb

    task put(input logic [7:0] v);
        bq[nq] = v;
        sq[nq] = 1'b0;
        nq++;
    endtask : put

    // most significant byte first
    task puts(input logic [79:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            put(w[i * 8 +: 8]);
        end
    endtask : puts

    // appends one descriptor to the byte list and works out the settings it should give
    task build(input mlp_row_s r, input logic [7:0] k, input logic [7:0] tag);
        int b0;
        logic [7:0] rv;
        logic [7:0] p;
        logic [15:0] c;
        logic [12:0] t;
        logic [12:0] q;
        logic [23:0] sr;
        logic [10:0] sv;
        logic [23:0] sm;
        b0 = nq;
        rv = 8'h96 + k;
        p = 8'h40 | k;
        c = {8'h9C, k};
        t = 13'h1ABC ^ {5'h00, k};
        q = 13'h0F0F ^ {5'h00, k};
        sr = {16'h1234, k};
        sv = 11'h5A5 ^ {3'h0, k};
        sm = {16'h7E55, k};
        exp = '0;
        exp.terminal_a = 8'h10 + k;
        exp.terminal_session_id = {8'hC0, k};
        exp.flags = {r.conn & ~r.bt, r.bt, r.sa, r.ma, r.f6[0], r.f6[1], r.f6[2], r.f6[3],
            r.f6[4], r.f6[5]};
        exp.uplink_sig_circuit_id = `MLP_SIG_VCI_DEF;
        exp.downlink_sig_circuit_id = `MLP_SIG_VCI_DEF;
        puts({tag, r.len, exp.terminal_a, exp.terminal_session_id, rv[1:0], r.f6}, 6);
        sq[b0] = 1'b1;
        if (r.bt) begin
            puts({r.ma, r.sa, 1'b1, t, rv[2:0], q}, 4);
            exp.uplink_traffic_packet_id = t;
            exp.uplink_control_packet_id = q;
        end else if (r.conn) begin
            puts({r.ma, r.sa, 2'b01, rv[3:0], p, c, rv, ~p, ~c}, 8);
            exp.uplink_sig_path_id = p;
            exp.uplink_sig_circuit_id = c;
            exp.downlink_sig_path_id = ~p;
            exp.downlink_sig_circuit_id = ~c;
        end else begin
            puts({r.ma, r.sa, 2'b00, rv[3:0], p, c}, 4);
            exp.uplink_path_id = p;
            exp.uplink_circuit_id = c;
        end
        if (!r.sa) begin
            puts({sr, rv[4:0], sv, sm, r.tmo}, 10);
            exp.star = {sr, sv, sm, r.tmo, r.tmo != 16'h0000};
        end
        if (!r.ma) begin
            puts({~sr, rv[7:3], ~sv, ~sm, r.tmo}, 10);
            exp.mesh = {~sr, ~sv, ~sm, r.tmo, r.tmo != 16'h0000};
        end
    endtask : build

    task wait_done;
        int i;
        i = 0;
        #1;
        while (parse_done !== 1'b1 && i < 40) begin
            @(posedge hclk);
            #1;
            i++;
        end
        if (parse_done !== 1'b1) begin
            bad_count++;
            finish_test();
        end
    endtask : wait_done

    // settings land two edges after the last byte; three leaves margin
    task settle;
        repeat (3) @(posedge hclk);
        #1;
    endtask : settle

    // main sequence: reset values, table rows, then the awkward cases
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        check("settings", settings, '0);
        check("valid", settings_valid, 1'b0);
        check("error", parse_error, 1'b0);
        check("hreadyout", hreadyout, 1'b1);
        check("hresp", hresp, 1'b0);
        ahb(1'b0, `MLP_A_CTRL, 32'h0);
        check("ctrl", rd, {16'h0000, `MLP_TAG_RST, 7'h00, `MLP_EN_RST});
        ahb(1'b1, 32'h3C, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h3C, 32'h0);
        check("unmapped", rd, 32'h0);
        for (int i = 0; i < 5; i++) begin
            nq = 0;
            build(rows[i], i[7:0], `MLP_TAG_RST);
            u_mlp_source.send(bq, sq, nq);
            wait_done();
            @(posedge hclk);
            #1;
            check("done", parse_done, 1'b0);
            check("settings", settings, exp);
            check("flags", settings.flags, exp.flags);
            check("star", settings.star, exp.star);
            check("mesh", settings.mesh, exp.mesh);
            check("valid", settings_valid, 1'b1);
            check("error", parse_error, 1'b0);
        end
        ahb(1'b0, `MLP_A_IDS, 32'h0);
        check("ids", rd, {8'h00, exp.terminal_session_id, exp.terminal_a});
        ahb(1'b0, `MLP_A_FLAGS, 32'h0);
        check("flagreg", rd, {22'h0, exp.flags});
        // one byte too many for the declared layout
        save = exp;
        nq = 0;
        build(rows[3], 8'h03, `MLP_TAG_RST);
        bq[1] = 8'h09;
        put(8'h00);
        u_mlp_source.send(bq, sq, nq);
        settle();
        check("error", parse_error, 1'b1);
        check("valid", settings_valid, 1'b0);
        check("kept", settings, save);
        ahb(1'b0, `MLP_A_STATUS, 32'h0);
        check("status", rd, 32'h0000_0001);
        ahb(1'b1, `MLP_A_STATUS, 32'h0000_0001);
        settle();
        check("cleared", parse_error, 1'b0);
        // tag filter and enable
        ahb(1'b1, `MLP_A_CTRL, 32'h0000_4701);
        nq = 0;
        build(rows[0], 8'h00, 8'h47);
        u_mlp_source.send(bq, sq, nq);
        wait_done();
        settle();
        check("newtag", settings, exp);
        save = exp;
        nq = 0;
        build(rows[1], 8'h01, `MLP_TAG_RST);
        u_mlp_source.send(bq, sq, nq);
        settle();
        check("othertag", settings, save);
        ahb(1'b1, `MLP_A_CTRL, 32'h0000_4700);
        nq = 0;
        build(rows[2], 8'h02, 8'h47);
        u_mlp_source.send(bq, sq, nq);
        settle();
        check("disabled", settings, save);
        check("error", parse_error, 1'b0);
        ahb(1'b1, `MLP_A_CTRL, {16'h0000, `MLP_TAG_RST, 8'h01});
        // empty body is shorter than any legal layout
        nq = 0;
        put(`MLP_TAG_RST);
        sq[0] = 1'b1;
        put(8'h00);
        u_mlp_source.send(bq, sq, nq);
        settle();
        check("error", parse_error, 1'b1);
        check("valid", settings_valid, 1'b0);
        ahb(1'b1, `MLP_A_STATUS, 32'h0000_0001);
        // aborted descriptor, then two clean ones back to back
        nq = 0;
        build(rows[1], 8'h01, `MLP_TAG_RST);
        nq = 6;
        build(rows[2], 8'h02, `MLP_TAG_RST);
        build(rows[0], 8'h00, `MLP_TAG_RST);
        u_mlp_source.send(bq, sq, nq);
        settle();
        check("error", parse_error, 1'b1);
        check("valid", settings_valid, 1'b1);
        check("last", settings, exp);
        // clock enable low: a whole descriptor goes by unseen and all state holds
        @(posedge hclk);
        ce <= 1'b0;
        save = exp;
        nq = 0;
        build(rows[3], 8'h03, `MLP_TAG_RST);
        u_mlp_source.send(bq, sq, nq);
        settle();
        check("frozen", settings, save);
        check("frozen done", parse_done, 1'b0);
        check("frozen error", parse_error, 1'b1);
        @(posedge hclk);
        ce <= 1'b1;
        finish_test();
    end
endmodule : testbench
